// ==== design/itfd_regs.vh ====
// Constants for the input terminal function decoder: register offsets,
// field positions, reset values, function codes and fault codes.
// Assumes a 40 MHz control clock and a 32-bit classic Wishbone slave.
`ifndef ITFD_REGS_VH
`define ITFD_REGS_VH

`define ITFD_NUM_TERM        8
`define ITFD_CODE_W          6

// Register byte offsets
`define ITFD_OFF_FUNC0       8'h00
`define ITFD_OFF_FUNC1       8'h04
`define ITFD_OFF_CFG         8'h08
`define ITFD_OFF_TERM        8'h0C
`define ITFD_OFF_REQ         8'h10
`define ITFD_OFF_STAT        8'h14
`define ITFD_OFF_PCOUNT      8'h18
`define ITFD_OFF_LCOUNT      8'h1C
`define ITFD_OFF_RTIME       8'h20

// Configuration register fields
`define ITFD_CFG_CMDSRC_LSB  0
`define ITFD_CFG_PIDDIR_BIT  2
`define ITFD_CFG_GAINSW_LSB  3
`define ITFD_CFG_CTLMODE_BIT 5
`define ITFD_CFG_RTEN_BIT    6
`define ITFD_CFG_UFRESP_LSB  8
`define ITFD_CFG_RESET       32'h0000_0001

// Field values
`define ITFD_CMDSRC_PANEL    2'h0
`define ITFD_CMDSRC_TERM     2'h1
`define ITFD_CMDSRC_COMM     2'h2
`define ITFD_GAINSW_TERM     2'h1

// Function codes
`define ITFD_FN_ACC1         6'h10
`define ITFD_FN_ACC2         6'h11
`define ITFD_FN_FSRC_SW      6'h12
`define ITFD_FN_UPDN_CLR     6'h13
`define ITFD_FN_CMD_SW1      6'h14
`define ITFD_FN_FREQ_HOLD    6'h15
`define ITFD_FN_PID_PAUSE    6'h16
`define ITFD_FN_SWING_PAUSE  6'h18
`define ITFD_FN_CNT_IN       6'h19
`define ITFD_FN_CNT_CLR      6'h1A
`define ITFD_FN_LEN_IN       6'h1B
`define ITFD_FN_LEN_CLR      6'h1C
`define ITFD_FN_TQ_BLOCK     6'h1D
`define ITFD_FN_DC_NOW       6'h20
`define ITFD_FN_EXT_FAULT    6'h21
`define ITFD_FN_FREQ_LOCK    6'h22
`define ITFD_FN_PID_REV      6'h23
`define ITFD_FN_EXT_STOP     6'h24
`define ITFD_FN_CMD_SW2      6'h25
`define ITFD_FN_PID_IPAUSE   6'h26
`define ITFD_FN_MAIN_PRESET  6'h27
`define ITFD_FN_AUX_PRESET   6'h28
`define ITFD_FN_MOTOR1       6'h29
`define ITFD_FN_MOTOR2       6'h2A
`define ITFD_FN_PID_GAIN     6'h2B
`define ITFD_FN_USER_F1      6'h2C
`define ITFD_FN_USER_F2      6'h2D
`define ITFD_FN_SPD_TQ       6'h2E
`define ITFD_FN_ESTOP        6'h2F
`define ITFD_FN_DEC_STOP     6'h30
`define ITFD_FN_DEC_DC       6'h31
`define ITFD_FN_RT_CLR       6'h32

// Fault codes reported on the fault output
`define ITFD_FAULT_NONE      6'h00
`define ITFD_FAULT_EXT       6'h0F
`define ITFD_FAULT_USER1     6'h1B
`define ITFD_FAULT_USER2     6'h1C

// Fourth deceleration time set index
`define ITFD_ACC_SET4        2'h3

`endif

// ==== design/itfd_sync.v ====
// Two-flop synchroniser bank for the raw terminal inputs.
// Assumes terminals are asynchronous contacts already debounced externally.
`timescale 1ns/1ps
`default_nettype none

module itfd_sync #(
	parameter W = 8
) (
	input  wire         clk_i,  // Control clock
	input  wire         rst_i,  // Synchronous reset, active high
	input  wire [W-1:0] d_i,    // Asynchronous inputs
	output reg  [W-1:0] q_o     // Synchronised inputs
);

	reg [W-1:0] meta;

	// First stage feeds only the second stage
	always @(posedge clk_i) begin
		if (rst_i) begin
			meta <= {W{1'b0}};
			q_o  <= {W{1'b0}};
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule // itfd_sync

`default_nettype wire

// ==== design/itfd_top.v ====
// Input terminal function decoder: maps eight digital terminals through
// their assigned function codes into drive requests, counters and faults.
// Assumes a 40 MHz clock, classic Wishbone register access and contact inputs.
//
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "itfd_regs.vh"

module itfd_top (
	input  wire        clk_i,            // Control clock, 40 MHz
	input  wire        rst_i,            // Synchronous reset, active high
	input  wire [7:0]  term_i,           // Raw terminal levels, high = ON
	input  wire        wb_cyc_i,         // Wishbone cycle
	input  wire        wb_stb_i,         // Wishbone strobe
	input  wire        wb_we_i,          // Wishbone write enable
	input  wire [7:0]  wb_adr_i,         // Wishbone byte address
	input  wire [3:0]  wb_sel_i,         // Wishbone byte selects
	input  wire [31:0] wb_dat_i,         // Wishbone write data
	output reg  [31:0] wb_dat_o,         // Wishbone read data
	output reg         wb_ack_o,         // Wishbone acknowledge
	output reg         wb_err_o,         // Wishbone error, unmapped address
	output reg  [1:0]  acc_set_o,        // Accel/decel time set 0..3
	output reg         freq_src_alt_o,   // Alternate frequency source active
	output reg         updn_clear_o,     // Drop UP/DOWN offset, use preset
	output reg  [1:0]  cmd_source_o,     // Effective command source
	output reg         freq_hold_o,      // Hold present output frequency
	output reg         pid_pause_o,      // Suspend PID, hold frequency
	output reg         pid_int_freeze_o, // Freeze PID integral term only
	output reg         pid_reverse_o,    // Effective PID direction
	output reg         pid_gain_sel_o,   // 0 = first gains, 1 = second gains
	output reg         swing_pause_o,    // Force swing centre frequency
	output reg         torque_mode_o,    // 1 = torque control, 0 = speed
	output reg         dc_brake_now_o,   // Enter DC braking at once
	output reg         dc_brake_dec_o,   // Decelerate then DC brake
	output reg         main_preset_o,    // Preset replaces main source
	output reg         aux_preset_o,     // Preset replaces aux source
	output reg  [1:0]  motor_sel_o,      // Motor parameter set 0..3
	output reg         stop_panel_o,     // Stop as panel stop key
	output reg         stop_dec4_o,      // Decelerating stop, set four
	output reg         stop_emerg_o,     // Emergency stop at current limit
	output reg         fault_o,          // Fault pending
	output reg  [5:0]  fault_code_o,     // Latched fault code
	output reg  [1:0]  fault_resp_o,     // Response for user faults
	output reg  [31:0] pulse_count_o,    // Pulse counter value
	output reg  [31:0] length_count_o,   // Length counter value
	output reg         rt_clear_o        // One-cycle running time clear
);

	// Terminal function assignments, four per register
	reg  [5:0]  func [0:7];
	reg  [31:0] cfg;
	reg  [7:0]  fault_stat;
	reg         swap_panel;   // Code 20 toggle state
	reg         to_comm;      // Code 37 latched move to comms
	reg  [7:0]  prev;
	wire [7:0]  term_s;
	integer     k;

	itfd_sync #(.W(8)) u_sync (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.d_i   (term_i),
		.q_o   (term_s)
	);

	// Level of any terminal carrying the given function code
	function fn_level;
		input [5:0]  code;
		input [7:0]  lv;
		input [47:0] fv;
		integer      i;
		begin
			fn_level = 1'b0;
			for (i = 0; i < 8; i = i + 1) begin
				if (fv[i*6 +: 6] == code && lv[i])
					fn_level = 1'b1;
			end
		end
	endfunction

	wire [47:0] fvec = {func[7], func[6], func[5], func[4],
	                    func[3], func[2], func[1], func[0]};
	wire [7:0]  rise = term_s & ~prev;

	// Decoded levels and rising edges
	wire lv_acc1   = fn_level(`ITFD_FN_ACC1, term_s, fvec);
	wire lv_acc2   = fn_level(`ITFD_FN_ACC2, term_s, fvec);
	wire lv_fsrc   = fn_level(`ITFD_FN_FSRC_SW, term_s, fvec);
	wire lv_updn   = fn_level(`ITFD_FN_UPDN_CLR, term_s, fvec);
	wire lv_hold   = fn_level(`ITFD_FN_FREQ_HOLD, term_s, fvec);
	wire lv_lock   = fn_level(`ITFD_FN_FREQ_LOCK, term_s, fvec);
	wire lv_pidp   = fn_level(`ITFD_FN_PID_PAUSE, term_s, fvec);
	wire lv_pidi   = fn_level(`ITFD_FN_PID_IPAUSE, term_s, fvec);
	wire lv_swing  = fn_level(`ITFD_FN_SWING_PAUSE, term_s, fvec);
	wire lv_cclr   = fn_level(`ITFD_FN_CNT_CLR, term_s, fvec);
	wire lv_lclr   = fn_level(`ITFD_FN_LEN_CLR, term_s, fvec);
	wire lv_tqblk  = fn_level(`ITFD_FN_TQ_BLOCK, term_s, fvec);
	wire lv_dcnow  = fn_level(`ITFD_FN_DC_NOW, term_s, fvec);
	wire lv_dcdec  = fn_level(`ITFD_FN_DEC_DC, term_s, fvec);
	wire lv_pidrev = fn_level(`ITFD_FN_PID_REV, term_s, fvec);
	wire lv_mainp  = fn_level(`ITFD_FN_MAIN_PRESET, term_s, fvec);
	wire lv_auxp   = fn_level(`ITFD_FN_AUX_PRESET, term_s, fvec);
	wire lv_mot1   = fn_level(`ITFD_FN_MOTOR1, term_s, fvec);
	wire lv_mot2   = fn_level(`ITFD_FN_MOTOR2, term_s, fvec);
	wire lv_gain   = fn_level(`ITFD_FN_PID_GAIN, term_s, fvec);
	wire lv_spdtq  = fn_level(`ITFD_FN_SPD_TQ, term_s, fvec);
	wire lv_estop  = fn_level(`ITFD_FN_ESTOP, term_s, fvec);
	wire lv_dec4   = fn_level(`ITFD_FN_DEC_STOP, term_s, fvec);
	wire lv_estp1  = fn_level(`ITFD_FN_EXT_STOP, term_s, fvec);
	wire ed_cnt    = fn_level(`ITFD_FN_CNT_IN, rise, fvec);
	wire ed_len    = fn_level(`ITFD_FN_LEN_IN, rise, fvec);
	wire ed_cmd1   = fn_level(`ITFD_FN_CMD_SW1, rise, fvec);
	wire ed_cmd2   = fn_level(`ITFD_FN_CMD_SW2, rise, fvec);
	wire ed_ext    = fn_level(`ITFD_FN_EXT_FAULT, rise, fvec);
	wire ed_uf1    = fn_level(`ITFD_FN_USER_F1, rise, fvec);
	wire ed_uf2    = fn_level(`ITFD_FN_USER_F2, rise, fvec);
	wire ed_rt     = fn_level(`ITFD_FN_RT_CLR, rise, fvec);

	wire [1:0] cmd_sel = cfg[`ITFD_CFG_CMDSRC_LSB +: 2];

	// Wishbone access decode; answers one cycle after the request
	wire wb_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire wb_wr    = wb_req & wb_we_i;
	wire fault_clr = wb_wr && wb_adr_i == `ITFD_OFF_STAT && wb_sel_i[0];
	wire a_func0  = wb_adr_i == `ITFD_OFF_FUNC0;
	wire a_func1  = wb_adr_i == `ITFD_OFF_FUNC1;
	wire a_cfg    = wb_adr_i == `ITFD_OFF_CFG;
	wire a_map    = a_func0 | a_func1 | a_cfg |
	                wb_adr_i == `ITFD_OFF_TERM | wb_adr_i == `ITFD_OFF_REQ |
	                wb_adr_i == `ITFD_OFF_STAT | wb_adr_i == `ITFD_OFF_PCOUNT |
	                wb_adr_i == `ITFD_OFF_LCOUNT;

	// Register writes; byte lanes honoured per slot
	always @(posedge clk_i) begin
		if (rst_i) begin
			for (k = 0; k < 8; k = k + 1)
				func[k] <= 6'h00;
			cfg <= `ITFD_CFG_RESET;
		end else if (wb_wr) begin
			for (k = 0; k < 4; k = k + 1) begin
				if (wb_sel_i[k] && a_func0)
					func[k] <= wb_dat_i[k*8 +: 6];
				if (wb_sel_i[k] && a_func1)
					func[k+4] <= wb_dat_i[k*8 +: 6];
				if (wb_sel_i[k] && a_cfg)
					cfg[k*8 +: 8] <= wb_dat_i[k*8 +: 8];
			end
		end
	end

	// Bus answer and read data
	always @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req & a_map;
			wb_err_o <= wb_req & ~a_map;
			wb_dat_o <= 32'h0000_0000;
			if (wb_req & ~wb_we_i) begin
				if (a_func0)
					wb_dat_o <= {2'h0, func[3], 2'h0, func[2], 2'h0, func[1], 2'h0, func[0]};
				else if (a_func1)
					wb_dat_o <= {2'h0, func[7], 2'h0, func[6], 2'h0, func[5], 2'h0, func[4]};
				else if (a_cfg)
					wb_dat_o <= cfg;
				else if (wb_adr_i == `ITFD_OFF_TERM)
					wb_dat_o <= {24'h00_0000, term_s};
				else if (wb_adr_i == `ITFD_OFF_REQ)
					wb_dat_o <= {16'h0000, stop_emerg_o, stop_dec4_o, stop_panel_o,
					             dc_brake_dec_o, dc_brake_now_o, torque_mode_o,
					             swing_pause_o, pid_gain_sel_o, pid_reverse_o,
					             pid_int_freeze_o, pid_pause_o, freq_hold_o,
					             cmd_source_o, motor_sel_o};
				else if (wb_adr_i == `ITFD_OFF_STAT)
					wb_dat_o <= {18'h0_0000, fault_code_o, fault_stat};
				else if (wb_adr_i == `ITFD_OFF_PCOUNT)
					wb_dat_o <= pulse_count_o;
				else if (wb_adr_i == `ITFD_OFF_LCOUNT)
					wb_dat_o <= length_count_o;
			end
		end
	end

	// Command source steering; the code-20 toggle only flips on an edge,
	// so a held contact does not oscillate the source
	always @(posedge clk_i) begin
		if (rst_i) begin
			swap_panel <= 1'b0;
			to_comm    <= 1'b0;
			prev       <= 8'h00;
		end else begin
			prev <= term_s;
			if (ed_cmd1 && (cmd_sel == `ITFD_CMDSRC_TERM || cmd_sel == `ITFD_CMDSRC_COMM))
				swap_panel <= ~swap_panel;
			if (ed_cmd2 && cmd_sel == `ITFD_CMDSRC_TERM)
				to_comm <= 1'b1;
			else if (cmd_sel != `ITFD_CMDSRC_TERM)
				to_comm <= 1'b0;
		end
	end

	// Request outputs, all registered
	always @(posedge clk_i) begin
		if (rst_i) begin
			acc_set_o        <= 2'h0;
			freq_src_alt_o   <= 1'b0;
			updn_clear_o     <= 1'b0;
			cmd_source_o     <= `ITFD_CMDSRC_TERM;
			freq_hold_o      <= 1'b0;
			pid_pause_o      <= 1'b0;
			pid_int_freeze_o <= 1'b0;
			pid_reverse_o    <= 1'b0;
			pid_gain_sel_o   <= 1'b0;
			swing_pause_o    <= 1'b0;
			torque_mode_o    <= 1'b0;
			dc_brake_now_o   <= 1'b0;
			dc_brake_dec_o   <= 1'b0;
			main_preset_o    <= 1'b0;
			aux_preset_o     <= 1'b0;
			motor_sel_o      <= 2'h0;
			stop_panel_o     <= 1'b0;
			stop_dec4_o      <= 1'b0;
			stop_emerg_o     <= 1'b0;
			fault_resp_o     <= 2'h0;
			rt_clear_o       <= 1'b0;
		end else begin
			// Decel stop always overrides the selected time set
			acc_set_o      <= lv_dec4 ? `ITFD_ACC_SET4 : {lv_acc2, lv_acc1};
			freq_src_alt_o <= lv_fsrc;
			updn_clear_o   <= lv_updn;
			if (to_comm)
				cmd_source_o <= `ITFD_CMDSRC_COMM;
			else if (swap_panel && cmd_sel != `ITFD_CMDSRC_PANEL)
				cmd_source_o <= `ITFD_CMDSRC_PANEL;
			else
				cmd_source_o <= cmd_sel;
			// Stop requests are separate outputs, so holding never masks them
			freq_hold_o      <= lv_hold | lv_lock | lv_pidp;
			pid_pause_o      <= lv_pidp;
			pid_int_freeze_o <= lv_pidi;
			pid_reverse_o    <= cfg[`ITFD_CFG_PIDDIR_BIT] ^ lv_pidrev;
			pid_gain_sel_o   <= (cfg[`ITFD_CFG_GAINSW_LSB +: 2] == `ITFD_GAINSW_TERM)
			                    & lv_gain;
			swing_pause_o    <= lv_swing;
			torque_mode_o    <= (cfg[`ITFD_CFG_CTLMODE_BIT] ^ lv_spdtq) & ~lv_tqblk;
			dc_brake_now_o   <= lv_dcnow;
			dc_brake_dec_o   <= lv_dcdec & ~lv_dcnow;
			main_preset_o    <= lv_mainp;
			aux_preset_o     <= lv_auxp;
			motor_sel_o      <= {lv_mot2, lv_mot1};
			stop_panel_o     <= lv_estp1 & (cmd_source_o == `ITFD_CMDSRC_PANEL);
			stop_dec4_o      <= lv_dec4;
			stop_emerg_o     <= lv_estop;
			fault_resp_o     <= cfg[`ITFD_CFG_UFRESP_LSB +: 2];
			rt_clear_o       <= ed_rt & cfg[`ITFD_CFG_RTEN_BIT];
		end
	end

	// Counters; a clear level holds the count at zero and wins over pulses
	always @(posedge clk_i) begin
		if (rst_i) begin
			pulse_count_o  <= 32'h0000_0000;
			length_count_o <= 32'h0000_0000;
		end else begin
			if (lv_cclr)
				pulse_count_o <= 32'h0000_0000;
			else if (ed_cnt)
				pulse_count_o <= pulse_count_o + 32'h0000_0001;
			if (lv_lclr)
				length_count_o <= 32'h0000_0000;
			else if (ed_len)
				length_count_o <= length_count_o + 32'h0000_0001;
		end
	end

	// Fault capture; a new event wins over a software clear in one cycle
	always @(posedge clk_i) begin
		if (rst_i) begin
			fault_stat   <= 8'h00;
			fault_code_o <= `ITFD_FAULT_NONE;
			fault_o      <= 1'b0;
		end else begin
			if (fault_clr)
				fault_stat <= fault_stat & ~wb_dat_i[7:0] |
				              {5'h00, ed_uf2, ed_uf1, ed_ext};
			else
				fault_stat <= fault_stat | {5'h00, ed_uf2, ed_uf1, ed_ext};
			if (ed_ext) begin
				fault_code_o <= `ITFD_FAULT_EXT;
				fault_o      <= 1'b1;
			end else if (ed_uf1) begin
				fault_code_o <= `ITFD_FAULT_USER1;
				fault_o      <= 1'b1;
			end else if (ed_uf2) begin
				fault_code_o <= `ITFD_FAULT_USER2;
				fault_o      <= 1'b1;
			end else if (fault_clr && (fault_stat & ~wb_dat_i[7:0]) == 8'h00) begin
				fault_code_o <= `ITFD_FAULT_NONE;
				fault_o      <= 1'b0;
			end
		end
	end

endmodule // itfd_top

`default_nettype wire

// ==== verification/itfd_contacts.sv ====
// Far-side model: the contacts wired to the eight digital input terminals.
// Assumes the bench names the wanted levels; contacts switch unrelated to the clock.
`timescale 1ns/1ps
`default_nettype none

module itfd_contacts (
	input  wire logic [7:0] want_i, // Wanted contact levels, high = closed
	output var  logic [7:0] term_o  // Levels seen at the terminals
);
	// Contacts settle a few ns off the clock grid, so the synchroniser is exercised
	assign #7 term_o = want_i;
endmodule // itfd_contacts

`default_nettype wire

// ==== verification/itfd_checker_sva.sv ====
// Checker for the input terminal function decoder, watching top-level ports.
// Assumes it is bound onto itfd_top and that the bus master keeps classic cycles.
`timescale 1ns/1ps
`default_nettype none
`include "itfd_regs.vh"

module itfd_checker (
	input wire logic        clk_i,          // Control clock
	input wire logic        rst_i,          // Synchronous reset
	input wire logic        wb_cyc_i,       // Bus cycle
	input wire logic        wb_stb_i,       // Bus strobe
	input wire logic        wb_ack_o,       // Bus acknowledge
	input wire logic        wb_err_o,       // Bus error
	input wire logic [31:0] wb_dat_o,       // Read data
	input wire logic [1:0]  acc_set_o,      // Time set
	input wire logic [1:0]  cmd_source_o,   // Command source
	input wire logic        freq_hold_o,    // Frequency hold
	input wire logic        pid_pause_o,    // PID pause
	input wire logic        dc_brake_now_o, // Immediate braking
	input wire logic        dc_brake_dec_o, // Braking after deceleration
	input wire logic        stop_panel_o,   // Panel-style stop
	input wire logic        stop_dec4_o,    // Stop on set four
	input wire logic        rt_clear_o,     // Running time clear
	input wire logic        fault_o,        // Fault pending
	input wire logic [5:0]  fault_code_o,   // Fault code
	input wire logic [31:0] pulse_count_o,  // Pulse counter
	input wire logic [31:0] length_count_o  // Length counter
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	// A taken request gets exactly one single-cycle answer
	sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o; endsequence
	sequence s_ans; ##1 (wb_ack_o || wb_err_o) ##1 !(wb_ack_o || wb_err_o); endsequence
	property p_bus_answer; s_req |-> s_ans; endproperty
	a_bus_answer: assert property (p_bus_answer) else $error("bus answer missing or long");
	property p_read_quiet; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
	a_read_quiet: assert property (p_read_quiet) else $error("read data outside ack");
	property p_err_alone; wb_err_o |-> !wb_ack_o; endproperty
	a_err_alone: assert property (p_err_alone) else $error("error and ack together");
	property p_dc_order; dc_brake_dec_o |-> !dc_brake_now_o; endproperty
	a_dc_order: assert property (p_dc_order) else $error("two braking requests");
	// The stop is registered from the source of the cycle before
	property p_panel_stop; stop_panel_o |-> $past(cmd_source_o) == `ITFD_CMDSRC_PANEL; endproperty
	a_panel_stop: assert property (p_panel_stop) else $error("panel stop off panel");
	property p_dec4; stop_dec4_o |-> acc_set_o == `ITFD_ACC_SET4; endproperty
	a_dec4: assert property (p_dec4) else $error("stop not on set four");
	property p_pid_pause; pid_pause_o |-> freq_hold_o; endproperty
	a_pid_pause: assert property (p_pid_pause) else $error("PID pause without hold");
	property p_rt_pulse; rt_clear_o |=> !rt_clear_o; endproperty
	a_rt_pulse: assert property (p_rt_pulse) else $error("running time clear too long");
	property p_fault_code;
		fault_o |-> fault_code_o inside {`ITFD_FAULT_EXT, `ITFD_FAULT_USER1, `ITFD_FAULT_USER2};
	endproperty
	a_fault_code: assert property (p_fault_code) else $error("bad fault code");
	// Counters only step by one or drop to zero
	property p_pulse_step;
		!$stable(pulse_count_o) |-> pulse_count_o == $past(pulse_count_o) + 1 || pulse_count_o == 0;
	endproperty
	a_pulse_step: assert property (p_pulse_step) else $error("pulse count jumped");
	property p_len_step;
		!$stable(length_count_o) |-> length_count_o == $past(length_count_o) + 1 || length_count_o == 0;
	endproperty
	a_len_step: assert property (p_len_step) else $error("length count jumped");
endmodule // itfd_checker

bind itfd_top itfd_checker i_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .wb_err_o,
	.wb_dat_o, .acc_set_o, .cmd_source_o, .freq_hold_o, .pid_pause_o, .dc_brake_now_o,
	.dc_brake_dec_o, .stop_panel_o, .stop_dec4_o, .rt_clear_o, .fault_o, .fault_code_o,
	.pulse_count_o, .length_count_o);

`default_nettype wire

// ==== verification/testbench.sv ====
// Self-checking bench for the input terminal function decoder.
// Assumes the contacts model on the terminals and a classic Wishbone master here.
`timescale 1ns/1ps
`default_nettype none
`include "itfd_regs.vh"

module testbench;
	logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i;
	logic [7:0] wb_adr_i, want;
	logic [3:0] wb_sel_i;
	logic [31:0] wb_dat_i, seed, expq[$];
	wire [7:0] term;
	wire [31:0] wb_dat_o, pulse_count_o, length_count_o;
	wire [1:0] acc_set_o, cmd_source_o, motor_sel_o, fault_resp_o;
	wire [5:0] fault_code_o;
	wire wb_ack_o, wb_err_o, freq_src_alt_o, updn_clear_o, freq_hold_o, pid_pause_o;
	wire pid_int_freeze_o, pid_reverse_o, pid_gain_sel_o, swing_pause_o, torque_mode_o;
	wire dc_brake_now_o, dc_brake_dec_o, main_preset_o, aux_preset_o, stop_panel_o;
	wire stop_dec4_o, stop_emerg_o, fault_o, rt_clear_o;
	int miscompares, checks_done, rt_pulses, i, k;

	itfd_contacts i_contacts (.want_i(want), .term_o(term));
	itfd_top i_dut (.clk_i, .rst_i, .term_i(term), .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
		.wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wb_err_o, .acc_set_o, .freq_src_alt_o,
		.updn_clear_o, .cmd_source_o, .freq_hold_o, .pid_pause_o, .pid_int_freeze_o,
		.pid_reverse_o, .pid_gain_sel_o, .swing_pause_o, .torque_mode_o, .dc_brake_now_o,
		.dc_brake_dec_o, .main_preset_o, .aux_preset_o, .motor_sel_o, .stop_panel_o,
		.stop_dec4_o, .stop_emerg_o, .fault_o, .fault_code_o, .fault_resp_o, .pulse_count_o,
		.length_count_o, .rt_clear_o);

	// Clock at 40 MHz
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("unexpected %s: expected %h, seen %h", name, exp, seen);
		end
	endtask

	task automatic final_report();
		$display("checks %0d, mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	function automatic logic [31:0] lfsr_next(input logic [31:0] s);
		lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	// One classic cycle; the wait is bounded so a silent slave cannot hang the run
	task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, input logic er);
		int n;
		n = 0;
		@(posedge clk_i);
		wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we; wb_adr_i <= a; wb_dat_i <= d;
		do begin
			@(posedge clk_i);
			n++;
		end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 20);
		if (n >= 20) begin
			miscompares++;
			final_report();
		end
		check("bus error", {31'h0, wb_err_o}, {31'h0, er});
		wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		expq.push_back(exp);
		wb(1'b0, a, 32'h0, 1'b0);
	endtask

	// Contact change, then time for two sync stages and the output register
	task automatic set_term(input logic [7:0] v);
		want <= v;
		repeat (6) @(posedge clk_i);
	endtask

	// Read data is compared against the oldest note when ack appears
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
			if (expq.size() == 0) check("read queue", 32'h1, 32'h0);
			else check("read data", wb_dat_o, expq.pop_front());
		end
		if (rt_clear_o === 1'b1) rt_pulses++;
	end

	// Level function codes and the output each one must raise
	function automatic logic [1:0] pick(input logic [5:0] c);
		case (c)
		`ITFD_FN_ACC1: pick = {1'b1, acc_set_o[0]};
		`ITFD_FN_ACC2: pick = {1'b1, acc_set_o[1]};
		`ITFD_FN_FSRC_SW: pick = {1'b1, freq_src_alt_o};
		`ITFD_FN_UPDN_CLR: pick = {1'b1, updn_clear_o};
		`ITFD_FN_FREQ_HOLD, `ITFD_FN_FREQ_LOCK: pick = {1'b1, freq_hold_o};
		`ITFD_FN_PID_PAUSE: pick = {1'b1, pid_pause_o};
		`ITFD_FN_SWING_PAUSE: pick = {1'b1, swing_pause_o};
		`ITFD_FN_DC_NOW: pick = {1'b1, dc_brake_now_o};
		`ITFD_FN_PID_REV: pick = {1'b1, pid_reverse_o};
		`ITFD_FN_EXT_STOP: pick = {1'b1, stop_panel_o};
		`ITFD_FN_PID_IPAUSE: pick = {1'b1, pid_int_freeze_o};
		`ITFD_FN_MAIN_PRESET: pick = {1'b1, main_preset_o};
		`ITFD_FN_AUX_PRESET: pick = {1'b1, aux_preset_o};
		`ITFD_FN_MOTOR1: pick = {1'b1, motor_sel_o[0]};
		`ITFD_FN_MOTOR2: pick = {1'b1, motor_sel_o[1]};
		`ITFD_FN_PID_GAIN: pick = {1'b1, pid_gain_sel_o};
		`ITFD_FN_SPD_TQ: pick = {1'b1, torque_mode_o};
		`ITFD_FN_ESTOP: pick = {1'b1, stop_emerg_o};
		`ITFD_FN_DEC_STOP: pick = {1'b1, stop_dec4_o};
		`ITFD_FN_DEC_DC: pick = {1'b1, dc_brake_dec_o};
		default: pick = 2'b00;
		endcase
	endfunction

	// Hang guard at 2 ms, far beyond the expected run length
	initial begin
		#2000000;
		miscompares++;
		final_report();
	end

	// Main sequence
	initial begin
		{wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, want} = '0;
		wb_sel_i = 4'hF;
		rst_i = 1'b1;
		seed = 32'h0001_1785;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		rd(`ITFD_OFF_CFG, `ITFD_CFG_RESET);
		check("cmd source", {30'h0, cmd_source_o}, 32'h1);
		wb(1'b0, 8'hFC, 32'h0, 1'b1);
		$display("test reset and map done");
		// Panel source, gain switch by terminal, running time on, user response 2
		wb(1'b1, `ITFD_OFF_CFG, 32'h0000_0248, 1'b0);
		for (i = 16; i < 50; i++) begin
			if (pick(i[5:0]) !== 2'b00) begin
				wb(1'b1, `ITFD_OFF_FUNC0, {26'h0, i[5:0]}, 1'b0);
				set_term(8'h01);
				check("level on", {30'h0, pick(i[5:0])}, 32'h3);
				set_term(8'h00);
				check("level off", {30'h0, pick(i[5:0])}, 32'h2);
			end
		end
		check("fault response", {30'h0, fault_resp_o}, 32'h2);
		$display("test level codes done");
		wb(1'b1, `ITFD_OFF_FUNC0, {26'h0, `ITFD_FN_RT_CLR}, 1'b0);
		set_term(8'h01);
		set_term(8'h00);
		wb(1'b1, `ITFD_OFF_CFG, 32'h0000_0208, 1'b0);
		set_term(8'h01);
		set_term(8'h00);
		check("rt pulses", rt_pulses, 32'h1);
		$display("test running time done");
		// Counter inputs on terminals 0 and 2, clears on 1 and 3
		wb(1'b1, `ITFD_OFF_FUNC0, 32'h1C1B_1A19, 1'b0);
		seed = lfsr_next(seed);
		for (k = 0; k <= seed[2:0]; k++) begin
			set_term(8'h01);
			set_term(8'h00);
		end
		for (k = 0; k <= seed[5:3]; k++) begin
			set_term(8'h04);
			set_term(8'h00);
		end
		rd(`ITFD_OFF_PCOUNT, {29'h0, seed[2:0]} + 32'h1);
		rd(`ITFD_OFF_LCOUNT, {29'h0, seed[5:3]} + 32'h1);
		set_term(8'h02);
		check("pulse clear", pulse_count_o, 32'h0);
		set_term(8'h08);
		check("length clear", length_count_o, 32'h0);
		set_term(8'h00);
		$display("test counters done");
		// Faults on terminals 4..6, command switch code 20 on terminal 7
		wb(1'b1, `ITFD_OFF_FUNC1, 32'h142D_2C21, 1'b0);
		for (k = 0; k < 3; k++) begin
			set_term(8'h10 << k);
			check("fault", {25'h0, fault_o, fault_code_o},
				{25'h0, 1'b1, k == 0 ? `ITFD_FAULT_EXT : k == 1 ? `ITFD_FAULT_USER1 : `ITFD_FAULT_USER2});
			set_term(8'h00);
			wb(1'b1, `ITFD_OFF_STAT, 32'h0000_0007, 1'b0);
			repeat (2) @(posedge clk_i);
			check("fault cleared", {31'h0, fault_o}, 32'h0);
		end
		$display("test faults done");
		wb(1'b1, `ITFD_OFF_CFG, 32'h0000_0201, 1'b0);
		set_term(8'h80);
		check("cmd toggle", {30'h0, cmd_source_o}, 32'h0);
		set_term(8'h00);
		set_term(8'h80);
		check("cmd toggle back", {30'h0, cmd_source_o}, 32'h1);
		set_term(8'h00);
		wb(1'b1, `ITFD_OFF_CFG, 32'h0000_0202, 1'b0);
		set_term(8'h80);
		check("cmd comm toggle", {30'h0, cmd_source_o}, 32'h0);
		set_term(8'h00);
		wb(1'b1, `ITFD_OFF_FUNC0, {24'h0, 2'h0, `ITFD_FN_CMD_SW2}, 1'b0);
		wb(1'b1, `ITFD_OFF_CFG, 32'h0000_0201, 1'b0);
		set_term(8'h01);
		check("cmd to comm", {30'h0, cmd_source_o}, 32'h2);
		set_term(8'h00);
		$display("test command source done");
		// Torque mode configured: code 29 blocks it, code 46 flips it
		wb(1'b1, `ITFD_OFF_FUNC0, {16'h0, 2'h0, `ITFD_FN_SPD_TQ, 2'h0, `ITFD_FN_TQ_BLOCK}, 1'b0);
		// PID direction set as well, with no code 35 terminal the output follows it
		wb(1'b1, `ITFD_OFF_CFG, 32'h0000_0225, 1'b0);
		repeat (3) @(posedge clk_i);
		check("torque idle", {31'h0, torque_mode_o}, 32'h1);
		check("pid direction", {31'h0, pid_reverse_o}, 32'h1);
		set_term(8'h01);
		check("torque blocked", {31'h0, torque_mode_o}, 32'h0);
		set_term(8'h02);
		check("torque flipped", {31'h0, torque_mode_o}, 32'h0);
		set_term(8'h00);
		$display("test control mode done");
		final_report();
	end
endmodule // testbench

`default_nettype wire
